// >>> ast_pkg.sv
// Constants, register map and state types of the asynchronous serial transceiver
package ast_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_MIN = 1200;
    localparam int OVERSAMPLE = 16;
    localparam int DIV_W = 10;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_V0 = 4'h7;
    localparam logic [3:0] TICK_V1 = 4'h8;
    localparam logic [3:0] TICK_DECIDE = 4'h9;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTL1 = 6'h05;
    localparam logic [5:0] IDX_CTL2 = 6'h06;
    localparam logic [5:0] IDX_STAT = 6'h07;
    localparam logic [5:0] IDX_RXD = 6'h08;
    localparam logic [5:0] IDX_TXD = 6'h09;
    localparam logic [5:0] IDX_FLAG = 6'h0F;
    localparam logic [5:0] IDX_MASK = 6'h10;
    // Field positions
    localparam int C1_TX9 = 7;
    localparam int C1_MODE = 5;
    localparam int C1_BAUD = 2;
    localparam int C1_TBE = 1;
    localparam int C1_TXE = 0;
    localparam int C2_INV = 3;
    localparam logic [7:0] C2_MASK = 8'h38;
    localparam int ST_RX9 = 7;
    localparam int ST_EVEN = 6;
    localparam int ST_PEN = 5;
    localparam int ST_PERR = 4;
    localparam int ST_OERR = 3;
    localparam int ST_FERR = 2;
    localparam int ST_RBF = 1;
    localparam int ST_RXE = 0;
    localparam int FL_SHIFT = 4;
    localparam int FL_TBE = 0;
    localparam int FL_RBF = 1;
    localparam int FL_ERR = 2;
    localparam logic [1:0] MODE_9BIT = 2'h3;
    localparam logic [1:0] MODE_8BIT = 2'h2;
    localparam logic [3:0] NBITS_7 = 4'h7;
    localparam logic [3:0] NBITS_8 = 4'h8;
    localparam logic [3:0] NBITS_9 = 4'h9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        AST_IDLE = 3'h0,
        AST_START = 3'h1,
        AST_DATA = 3'h3,
        AST_PAR = 3'h2,
        AST_STOP = 3'h6
    } ast_ser_t;

    typedef struct packed {
        logic awrdy;
        logic aw_ok;
        logic [5:0] aw_idx;
        logic wrdy;
        logic w_ok;
        logic [7:0] w_data;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } ast_bus_t;

    typedef struct packed {
        ast_ser_t state;
        logic [DIV_W-1:0] div;
        logic [3:0] tick;
        logic [3:0] nbit;
        logic [8:0] shift;
        logic line;
    } ast_tx_t;

    typedef struct packed {
        ast_ser_t state;
        logic [2:0] sync;
        logic lvl;
        logic prev;
        logic [DIV_W-1:0] div;
        logic [3:0] tick;
        logic [3:0] nbit;
        logic [1:0] ones;
        logic [8:0] shift;
        logic par;
    } ast_rx_t;

    typedef struct packed {
        ast_bus_t bus;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] stat;
        logic [7:0] rx_data;
        logic [8:0] tx_hold;
        logic [2:0] flags;
        logic [2:0] mask;
        ast_tx_t tx;
        ast_rx_t rx;
        logic tx_pin;
        logic irq;
    } ast_state_t;

    // Oversampling divisor; baud doubles with each select step
    function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
        int d;
        d = CLK_HZ / ((BAUD_MIN << sel) * OVERSAMPLE) - 1;
        return DIV_W'(d);
    endfunction

    function automatic logic [3:0] data_bits(input logic [1:0] mode);
        return (mode == MODE_9BIT) ? NBITS_9 : ((mode == MODE_8BIT) ? NBITS_8 : NBITS_7);
    endfunction
endpackage

// >>> ast_remote.sv
// Remote serial device model facing the transceiver's line pins
`timescale 1ns/1ps
`default_nettype none
module ast_remote #(
    parameter int BIT = 64
) (
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_line
);
    int nb = 8;
    logic pe = 1'b0;
    logic [10:0] got[$];
    logic [8:0] d;
    logic p;
    logic ok;

    initial o_line = 1'b1;

    // Mid-bit sampling; a start that is not still low counts as a bad stop
    initial begin
        forever begin
            @(posedge i_clk);
            if (i_line === 1'b0) begin
                repeat (BIT / 2) @(posedge i_clk);
                ok = (i_line === 1'b0);
                d = 9'h000;
                p = 1'b0;
                for (int i = 0; i < nb; i++) begin
                    repeat (BIT) @(posedge i_clk);
                    d[i] = i_line;
                end
                if (pe) begin
                    repeat (BIT) @(posedge i_clk);
                    p = i_line;
                end
                repeat (BIT) @(posedge i_clk);
                got.push_back({ok & i_line, p, d});
            end
        end
    end

    task automatic send(input logic [8:0] v, input int n, input logic pen, input logic pb,
                        input logic sb);
        o_line <= 1'b0;
        repeat (BIT) @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            o_line <= v[i];
            repeat (BIT) @(posedge i_clk);
        end
        if (pen) begin
            o_line <= pb;
            repeat (BIT) @(posedge i_clk);
        end
        o_line <= sb;
        repeat (BIT) @(posedge i_clk);
        o_line <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask

    // Short low pulse, then a full idle bit so a false start cannot hide
    task automatic pulse(input int n);
        o_line <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_line <= 1'b1;
        repeat (BIT) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// >>> ast_top.sv
// Asynchronous serial transceiver with AXI4-Lite register slave
// Contract
// RL1 - Line idles high; each character starts with a drop to low.
// RL2 - Frame: low start, data LSB first, optional parity, high stop.
// RL3 - Start accepted only when two of three mid-bit samples read zero.
// RL4 - Modes: 7 bits, 8 bits with optional parity; 9-bit mode never has parity.
// RL5 - Transmitter shifts 7, 8 or 9 data bits, LSB first.
// RL6 - Ninth transmit bit from control field; ninth receive bit into status.
// RL7 - Transmit only while enabled; data write sets buffer flag, then sends.
// RL8 - One parity bit, odd or even per parity-select bit.
// RL9 - One high stop bit, then line held high until next start.
// RL10 - After stop bit set transmit-empty flag; interrupt if enabled.
// RL11 - Receive only while receive enable set; then watch for start bits.
// RL12 - Receiver shifts data LSB first, then takes parity and stop.
// RL13 - Each received character sets receive-full flag and buffer-full bit.
// RL14 - Parity error when ones count disagrees with selected sense.
// RL15 - Framing error unless start sampled 0 and stop sampled 1.
// RL16 - Overrun when new character arrives while buffer-full still set.
// RL17 - Failed check sets its error bit and error flag; interrupt if enabled.
// RL18 - Software clears error bits; left set, error flag rises again next char.
// RL19 - Reading receive data clears buffer-full bit.
// RL20 - Baud generator for both directions, rate from 3-bit select field.
// RL21 - Independent, double-buffered transmit and receive paths.
// RL22 - Bit period divides system clock; receive count restarts at start.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ast_top
    import ast_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire logic [7:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [31:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [7:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [31:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    input wire logic I_RX,
    output logic O_TX,
    output logic O_IRQ
);
    ast_state_t st;
    ast_state_t next_st;

    logic rx_s;
    logic vote;
    logic rx_done;
    logic rx_load;
    logic rd_rxd;
    logic tx_tick;
    logic rx_tick;
    logic tx_bit_end;
    logic [3:0] nbits;
    logic par_on;
    logic [8:0] rx_word;

    assign nbits = data_bits(st.ctl1[C1_MODE+:2]);
    assign par_on = st.stat[ST_PEN] && (st.ctl1[C1_MODE+:2] != MODE_9BIT); // RL4
    assign rx_s = st.rx.lvl ^ st.ctl2[C2_INV];
    assign tx_tick = (st.tx.div == baud_div(st.ctl1[C1_BAUD+:3])); // RL20
    assign rx_tick = (st.rx.div == baud_div(st.ctl1[C1_BAUD+:3]));
    assign tx_bit_end = tx_tick && (st.tx.tick == TICK_LAST);
    // Majority of samples 7, 8 and the one at 9
    assign vote = (2'(st.rx.ones) + 2'(rx_s)) >= 2'h2; // RL3
    assign rx_done = rx_tick && (st.rx.tick == TICK_DECIDE) && (st.rx.state == AST_STOP);
    assign rx_load = rx_done && !st.stat[ST_RBF]; // RL16
    assign rd_rxd = I_AXI_ARVALID && st.bus.arrdy && (I_AXI_ARADDR[7:2] == IDX_RXD);
    assign rx_word = st.rx.shift >> (NBITS_9 - nbits);

    always_comb begin
        logic wr;
        logic [7:0] rd;
        logic [5:0] ridx;
        logic perr;
        logic ferr;
        logic oerr;
        wr = 1'b0;
        rd = 8'h00;
        ridx = I_AXI_ARADDR[7:2];
        perr = 1'b0;
        ferr = 1'b0;
        oerr = 1'b0;
        next_st = st;

        // Write channel: address and data in either order
        if (I_AXI_AWVALID && st.bus.awrdy) begin
            next_st.bus.aw_ok = 1'b1;
            next_st.bus.aw_idx = I_AXI_AWADDR[7:2];
        end
        if (I_AXI_WVALID && st.bus.wrdy) begin
            next_st.bus.w_ok = 1'b1;
            next_st.bus.w_data = I_AXI_WDATA[7:0];
            next_st.bus.w_en = I_AXI_WSTRB[0];
        end
        if (I_AXI_BREADY && st.bus.bvalid) begin
            next_st.bus.bvalid = 1'b0;
        end
        if (st.bus.aw_ok && st.bus.w_ok && !st.bus.bvalid) begin
            wr = st.bus.w_en;
            next_st.bus.aw_ok = 1'b0;
            next_st.bus.w_ok = 1'b0;
            next_st.bus.bvalid = 1'b1;
            next_st.bus.bresp = RESP_OKAY;
            unique case (st.bus.aw_idx)
                IDX_CTL1, IDX_CTL2, IDX_STAT, IDX_RXD, IDX_TXD, IDX_FLAG, IDX_MASK: begin
                end
                default: next_st.bus.bresp = RESP_SLVERR;
            endcase
        end
        if (wr) begin
            unique case (st.bus.aw_idx)
                // Buffer flag is hardware-owned; software cannot set or clear it
                IDX_CTL1: next_st.ctl1 = {st.bus.w_data[7:2], st.ctl1[C1_TBE], st.bus.w_data[0]};
                IDX_CTL2: next_st.ctl2 = st.bus.w_data & C2_MASK;
                IDX_STAT: next_st.stat = {st.bus.w_data[7:2], st.stat[ST_RBF], st.bus.w_data[0]};
                IDX_TXD: begin
                    next_st.tx_hold = {st.ctl1[C1_TX9], st.bus.w_data}; // RL6
                    next_st.ctl1[C1_TBE] = 1'b1; // RL7
                end
                IDX_FLAG: next_st.flags = st.bus.w_data[FL_SHIFT+:3];
                IDX_MASK: next_st.mask = st.bus.w_data[FL_SHIFT+:3];
                default: begin
                end
            endcase
        end
        next_st.ctl1[C1_TBE] = next_st.ctl1[C1_TBE] | (wr && st.bus.aw_idx == IDX_TXD);

        // Read channel
        if (I_AXI_RREADY && st.bus.rvalid) begin
            next_st.bus.rvalid = 1'b0;
        end
        if (I_AXI_ARVALID && st.bus.arrdy) begin
            next_st.bus.rvalid = 1'b1;
            next_st.bus.rresp = RESP_OKAY;
            unique case (ridx)
                IDX_CTL1: rd = st.ctl1;
                IDX_CTL2: rd = st.ctl2;
                IDX_STAT: rd = st.stat;
                IDX_RXD: rd = st.rx_data;
                IDX_TXD: rd = 8'h00;
                IDX_FLAG: rd = {1'b0, st.flags, 4'h0};
                IDX_MASK: rd = {1'b0, st.mask, 4'h0};
                default: next_st.bus.rresp = RESP_SLVERR;
            endcase
            next_st.bus.rdata = rd;
        end
        if (rd_rxd) begin
            next_st.stat[ST_RBF] = 1'b0; // RL19
        end

        // Transmitter: free-running divider
        next_st.tx.div = tx_tick ? '0 : st.tx.div + 1'b1; // RL22
        if (tx_tick) begin
            next_st.tx.tick = st.tx.tick + 1'b1;
        end
        unique case (st.tx.state)
            AST_IDLE: begin
                next_st.tx.line = 1'b1; // RL1
                if (st.ctl1[C1_TXE] && st.ctl1[C1_TBE] && tx_tick) begin // RL7
                    // Unused upper bits cleared so the rotated word carries only data
                    next_st.tx.shift = rx_par_src(st.tx_hold, nbits); // RL21
                    next_st.ctl1[C1_TBE] = next_st.ctl1[C1_TBE] & wr & (st.bus.aw_idx == IDX_TXD);
                    next_st.tx.state = AST_START;
                    next_st.tx.tick = '0;
                    next_st.tx.line = 1'b0; // RL2
                end
            end
            AST_START: if (tx_bit_end) begin
                next_st.tx.state = AST_DATA;
                next_st.tx.nbit = '0;
                next_st.tx.line = st.tx.shift[0];
            end
            AST_DATA: if (tx_bit_end) begin
                // Rotate, not shift: parity at the last data bit is taken over the whole word
                next_st.tx.shift = {st.tx.shift[0], st.tx.shift[8:1]}; // RL5
                next_st.tx.nbit = st.tx.nbit + 1'b1;
                if (st.tx.nbit + 1'b1 == nbits) begin
                    next_st.tx.state = par_on ? AST_PAR : AST_STOP;
                    // Even sense: bit makes total ones even
                    next_st.tx.line = par_on ? (^st.tx.shift ^ !st.stat[ST_EVEN]) : 1'b1; // RL8
                end else begin
                    next_st.tx.line = st.tx.shift[1];
                end
            end
            AST_PAR: if (tx_bit_end) begin
                next_st.tx.state = AST_STOP;
                next_st.tx.line = 1'b1; // RL9
            end
            AST_STOP: if (tx_bit_end) begin
                next_st.tx.state = AST_IDLE;
                next_st.flags[FL_TBE] = 1'b1; // RL10
            end
            default: next_st.tx.state = AST_IDLE;
        endcase

        // Receiver: three-stage pin synchroniser, agreement of last two
        next_st.rx.sync = {st.rx.sync[1:0], I_RX};
        if (st.rx.sync[1] == st.rx.sync[2]) begin
            next_st.rx.lvl = st.rx.sync[2];
        end
        next_st.rx.prev = rx_s;
        next_st.rx.div = rx_tick ? '0 : st.rx.div + 1'b1;
        if (rx_tick) begin
            next_st.rx.tick = st.rx.tick + 1'b1;
            if (st.rx.tick == TICK_V0 || st.rx.tick == TICK_V1) begin
                next_st.rx.ones = st.rx.ones + 2'(rx_s);
            end
            if (st.rx.tick == TICK_DECIDE) begin
                next_st.rx.ones = '0;
            end
        end
        unique case (st.rx.state)
            AST_IDLE: if (st.stat[ST_RXE] && st.rx.prev && !rx_s) begin // RL11
                next_st.rx.state = AST_START;
                next_st.rx.div = '0; // RL22
                next_st.rx.tick = '0;
                next_st.rx.ones = '0;
                next_st.rx.nbit = '0;
            end
            AST_START: if (rx_tick && st.rx.tick == TICK_DECIDE && vote) begin
                next_st.rx.state = AST_IDLE; // RL3
            end else if (rx_tick && st.rx.tick == TICK_LAST) begin
                next_st.rx.state = AST_DATA;
            end
            AST_DATA: begin
                if (rx_tick && st.rx.tick == TICK_DECIDE) begin
                    next_st.rx.shift = {vote, st.rx.shift[8:1]}; // RL12
                    next_st.rx.nbit = st.rx.nbit + 1'b1;
                end
                if (rx_tick && st.rx.tick == TICK_LAST && st.rx.nbit == nbits) begin
                    next_st.rx.state = par_on ? AST_PAR : AST_STOP;
                end
            end
            AST_PAR: begin
                if (rx_tick && st.rx.tick == TICK_DECIDE) begin
                    next_st.rx.par = vote;
                end
                if (rx_tick && st.rx.tick == TICK_LAST) begin
                    next_st.rx.state = AST_STOP;
                end
            end
            AST_STOP: if (rx_done) begin
                // Finish at mid stop bit so a back-to-back start edge is seen
                next_st.rx.state = AST_IDLE;
                ferr = !vote; // RL15
                perr = par_on && (^rx_word ^ st.rx.par ^ !st.stat[ST_EVEN]); // RL14
                oerr = st.stat[ST_RBF]; // RL16
            end
            default: next_st.rx.state = AST_IDLE;
        endcase
        if (rx_load) begin
            next_st.rx_data = rx_word[7:0];
            next_st.stat[ST_RX9] = rx_word[8] & (nbits == NBITS_9); // RL6
        end
        if (rx_done) begin
            next_st.stat[ST_RBF] = 1'b1; // RL13
            next_st.flags[FL_RBF] = 1'b1; // RL13
            next_st.stat[ST_PERR] = next_st.stat[ST_PERR] | perr; // RL17
            next_st.stat[ST_OERR] = next_st.stat[ST_OERR] | oerr; // RL17
            next_st.stat[ST_FERR] = next_st.stat[ST_FERR] | ferr; // RL17
            // Stale error bits re-raise the flag on every character
            if (perr || oerr || ferr || st.stat[ST_PERR] || st.stat[ST_OERR] ||
                st.stat[ST_FERR]) begin
                next_st.flags[FL_ERR] = 1'b1; // RL18
            end
        end

        next_st.bus.awrdy = !next_st.bus.aw_ok;
        next_st.bus.wrdy = !next_st.bus.w_ok;
        next_st.bus.arrdy = !next_st.bus.rvalid;
        next_st.tx_pin = next_st.tx.line ^ next_st.ctl2[C2_INV];
        next_st.irq = |(next_st.flags & next_st.mask); // RL17
    end

    // Data bits of the held word used for parity
    function automatic logic [8:0] rx_par_src(input logic [8:0] w, input logic [3:0] n);
        return w & ~(9'h1FF << n);
    endfunction

    always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            st <= '0;
            st.tx.line <= 1'b1;
            st.tx_pin <= 1'b1;
            st.rx.sync <= 3'h7;
            st.rx.lvl <= 1'b1;
            st.rx.prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign O_AXI_AWREADY = st.bus.awrdy;
    assign O_AXI_WREADY = st.bus.wrdy;
    assign O_AXI_BVALID = st.bus.bvalid;
    assign O_AXI_BRESP = st.bus.bresp;
    assign O_AXI_ARREADY = st.bus.arrdy;
    assign O_AXI_RVALID = st.bus.rvalid;
    assign O_AXI_RRESP = st.bus.rresp;
    assign O_AXI_RDATA = {24'h000000, st.bus.rdata};
    assign O_TX = st.tx_pin;
    assign O_IRQ = st.irq;

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);

    a_tx_idle_mark: assert property (st.tx.state == AST_IDLE |-> st.tx.line) // RL1
        else $error("line not high while idle");
    a_tx_start_low: assert property ($rose(st.tx.state == AST_START) |-> !st.tx.line) // RL2
        else $error("start bit not low");
    a_tx_disabled: assert property (st.tx.state == AST_IDLE && !st.ctl1[C1_TXE]
        |=> st.tx.state == AST_IDLE) // RL7
        else $error("transmit left idle while disabled");
    a_tx_stop_flag: assert property (st.tx.state == AST_STOP && tx_bit_end
        |=> st.flags[FL_TBE] && st.tx.line) // RL10
        else $error("empty flag missing after stop bit");
    a_rx_disabled: assert property (st.rx.state == AST_IDLE && !st.stat[ST_RXE]
        |=> st.rx.state == AST_IDLE) // RL11
        else $error("receiver left idle while disabled");
    a_rx_full_set: assert property (rx_done |=> st.stat[ST_RBF] && st.flags[FL_RBF]) // RL13
        else $error("buffer full not set after character");
    a_rx_frame_err: assert property (rx_done && !vote |=> st.stat[ST_FERR]) // RL15
        else $error("framing error not flagged");
    a_rx_overrun: assert property (rx_done && st.stat[ST_RBF]
        |=> st.stat[ST_OERR] && $stable(st.rx_data)) // RL16
        else $error("overrun not flagged or data overwritten");
    a_read_clears: assert property (rd_rxd && !rx_done |=> !st.stat[ST_RBF]) // RL19
        else $error("read did not clear buffer full");
    a_start_reject: assert property (st.rx.state == AST_START && rx_tick &&
        st.rx.tick == TICK_DECIDE && vote |=> st.rx.state == AST_IDLE) // RL3
        else $error("false start accepted");

    c_tx_frame: cover property (st.tx.state == AST_STOP ##1 st.tx.state == AST_IDLE);
    c_rx_char: cover property (rx_load);
    c_rx_parity_err: cover property (rx_done ##1 st.stat[ST_PERR]);
endmodule
`default_nettype wire

// >>> test_async_serial_transceiver.sv
// Self-checking bench for the asynchronous serial transceiver
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_transceiver
    import ast_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    logic awr, wrdy, bv, arr, rv, tx, irq, rxl;
    int fail_count = 0;
    int compares = 0;

    ast_top dut_u (
        .I_CLK_SYS(clk), .I_NRST(nrst), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awv),
        .O_AXI_AWREADY(awr), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wv),
        .O_AXI_WREADY(wrdy), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bv), .I_AXI_BREADY(bry),
        .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
        .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rv), .I_AXI_RREADY(rry),
        .I_RX(rxl), .O_TX(tx), .O_IRQ(irq)
    );
    // Fastest baud select: 64 clocks per bit
    ast_remote #(.BIT(64)) rm_u (.i_clk(clk), .i_line(tx), .o_line(rxl));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic results();
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tmo();
        chk(34'h0, 34'h1);
        results();
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] v,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        awaddr <= {idx, 2'h0};
        wd <= {24'h000000, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            n++;
            if (n > 100) tmo();
        end while (bv !== 1'b1);
        bry <= 1'b0;
        chk({bresp, 32'h0}, {er, 32'h0});
        @(posedge clk);
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [7:0] e,
                       input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        araddr <= {idx, 2'h0};
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            n++;
            if (n > 100) tmo();
        end while (rv !== 1'b1);
        rry <= 1'b0;
        chk({rresp, rdata}, {er, 24'h000000, e});
        @(posedge clk);
    endtask

    // Repeated reads until one bit reaches a value
    task automatic poll(input logic [5:0] idx, input int b, input logic v);
        int w;
        for (int n = 0; n < 300; n++) begin
            araddr <= {idx, 2'h0};
            arv <= 1'b1;
            rry <= 1'b1;
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (arr !== 1'b1 && w < 100);
            arv <= 1'b0;
            do begin
                @(posedge clk);
                w++;
            end while (rv !== 1'b1 && w < 200);
            if (w >= 200) tmo();
            rry <= 1'b0;
            @(posedge clk);
            if (rdata[b] === v) return;
        end
        tmo();
    endtask

    task automatic getq(input logic [10:0] e);
        for (int n = 0; rm_u.got.size() == 0; n++) begin
            @(posedge clk);
            if (n > 2000) tmo();
        end
        chk({23'h0, rm_u.got.pop_front()}, {23'h0, e});
    endtask

    function automatic logic [10:0] fr(input logic [8:0] d, input int nb, input logic pe,
                                       input logic ev);
        logic [8:0] m;
        m = d & ((9'h001 << nb) - 9'h001);
        return {1'b1, pe & (ev ? ^m : ~^m), m};
    endfunction

    initial begin
        logic [5:0] ix[7] = '{IDX_CTL1, IDX_CTL2, IDX_STAT, IDX_RXD, IDX_TXD, IDX_FLAG, IDX_MASK};
        logic [7:0] c1s[3] = '{8'h3D, 8'h5D, 8'hFD};
        logic [7:0] sts[3] = '{8'h60, 8'h20, 8'h20};
        logic [7:0] ds[3] = '{8'h0B, 8'hA6, 8'h5A};
        int nbs[3] = '{7, 8, 9};
        logic [7:0] pre[6] = '{8'h61, 8'h71, 8'h61, 8'h61, 8'h61, 8'h60};
        logic [7:0] rvs[6] = '{8'h3C, 8'h55, 8'h11, 8'h12, 8'h34, 8'h0F};
        logic [5:0] pbs = 6'b010001;
        logic [5:0] sbs = 6'b111011;
        logic [7:0] st2[6] = '{8'h73, 8'h73, 8'h67, 8'h63, 8'h6B, 8'h60};
        logic [7:0] fls[6] = '{8'h60, 8'h60, 8'h60, 8'h20, 8'h60, 8'h00};
        logic [8:0] rxs[6] = '{9'h13C, 9'h155, 9'h111, 9'h000, 9'h112, 9'h000};
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 7; k++) rdc(ix[k], 8'h00);
        rdc(6'h01, 8'h00, RESP_SLVERR);
        wr(6'h02, 8'hFF, RESP_SLVERR);
        wr(IDX_CTL2, 8'hFF);
        rdc(IDX_CTL2, C2_MASK);
        wr(IDX_CTL2, 8'h00);
        wr(IDX_CTL1, 8'h02);
        rdc(IDX_CTL1, 8'h00);
        // Invert test drove the line low; let the partner drain that false frame
        repeat (800) @(posedge clk);
        rm_u.got.delete();
        $display("test reset_map done");
        for (int k = 0; k < 3; k++) begin
            rm_u.nb = nbs[k];
            rm_u.pe = (k < 2);
            wr(IDX_STAT, sts[k]);
            wr(IDX_FLAG, 8'h00);
            wr(IDX_CTL1, c1s[k] & 8'hFE);
            wr(IDX_TXD, ds[k]);
            rdc(IDX_CTL1, (c1s[k] & 8'hFE) | 8'h02);
            chk({33'h0, tx}, 34'h1);
            wr(IDX_CTL1, c1s[k]);
            if (k == 1) begin
                poll(IDX_CTL1, C1_TBE, 1'b0);
                wr(IDX_TXD, 8'h35);
            end
            getq(fr({c1s[k][7], ds[k]}, nbs[k], k < 2, sts[k][ST_EVEN]));
            if (k == 1) getq(fr(9'h035, 8, 1'b1, 1'b0));
            poll(IDX_FLAG, FL_SHIFT + FL_TBE, 1'b1);
        end
        chk({33'h0, tx}, 34'h1);
        wr(IDX_MASK, 8'h10);
        repeat (2) @(posedge clk);
        chk({33'h0, irq}, 34'h1);
        wr(IDX_FLAG, 8'h00);
        repeat (2) @(posedge clk);
        chk({33'h0, irq}, 34'h0);
        $display("test transmit done");
        rm_u.nb = 8;
        rm_u.pe = 1'b1;
        wr(IDX_CTL1, 8'h5D);
        wr(IDX_STAT, 8'h61);
        fork
            rm_u.send(9'h03C, 8, 1'b1, 1'b0, 1'b1);
            wr(IDX_TXD, 8'hC3);
        join
        getq(fr(9'h0C3, 8, 1'b1, 1'b1));
        rdc(IDX_STAT, 8'h63);
        rdc(IDX_RXD, 8'h3C);
        rdc(IDX_STAT, 8'h61);
        for (int k = 0; k < 6; k++) begin
            wr(IDX_STAT, pre[k]);
            wr(IDX_FLAG, 8'h00);
            rm_u.send({1'b0, rvs[k]}, 8, 1'b1, pbs[k], sbs[k]);
            rdc(IDX_STAT, st2[k]);
            rdc(IDX_FLAG, fls[k]);
            if (rxs[k][8]) rdc(IDX_RXD, rxs[k][7:0]);
        end
        wr(IDX_STAT, 8'h61);
        wr(IDX_CTL1, 8'h7C);
        rm_u.pulse(8);
        rm_u.send(9'h1A5, 9, 1'b0, 1'b0, 1'b1);
        rdc(IDX_STAT, 8'hE3);
        rdc(IDX_RXD, 8'hA5);
        $display("test receive done");
        results();
    end
endmodule
`default_nettype wire
